// ==== core/lsip_pkg.sv ====
// shared constants and types of the light sensor two-wire port
package lsip_pkg;
	// system clock period and link speed limits
	localparam int CLK_NS = 100;
	localparam int FS_MAX_KHZ = 400;
	localparam int HS_MAX_KHZ = 2600;
	// register pointer values
	localparam logic [7:0] PTR_OUTPUT_SAMPLE = 8'h00;
	localparam logic [7:0] PTR_OPERATING_CONTROL = 8'h01;
	localparam logic [7:0] PTR_LOWER_THRESHOLD = 8'h02;
	localparam logic [7:0] PTR_UPPER_THRESHOLD = 8'h03;
	localparam logic [7:0] PTR_MAKER_IDENTIFIER = 8'h7E;
	// reset values and writable bits
	localparam logic [15:0] SAMPLE_RST = 16'h0000;
	localparam logic [15:0] CONTROL_RST = 16'hC810;
	localparam logic [15:0] CONTROL_WMASK = 16'hFE1F;
	localparam logic [7:0] PTR_RST = 8'h00;
	// operating_control field positions
	localparam int CTL_MODE_HI = 10;
	localparam int CTL_MODE_LO = 9;
	localparam int CTL_LATCH = 4;
	localparam int CTL_OUTPUT_POLARITY = 3;
	// special bus bytes
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [7:0] GC_RESET = 8'h06;
	localparam logic [7:0] ARA_BYTE = 8'h19;
	localparam logic [4:0] HS_CODE = 5'h01;
	localparam logic [6:0] TGT_ADDR_BASE = 7'h44;
	// host byte commands
	localparam logic [1:0] OP_START = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_STOP = 2'h3;
	// target protocol states
	typedef enum logic [6:0] {
		T_IDLE = 7'h01,
		T_ADDR = 7'h02,
		T_PTR = 7'h04,
		T_WR = 7'h08,
		T_RD = 7'h10,
		T_GC = 7'h20,
		T_ARA = 7'h40
	} lsip_tgt_st_t;
	// host sequencer states
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_BIT = 4'h4,
		H_STOP = 4'h8
	} lsip_ctl_st_t;
endpackage

// ==== core/lsip_if.sv ====
// open-drain two-wire link joining controller and target
`timescale 1ns/1ns
interface lsip_if;
	// controller drives
	logic scl_o;
	logic scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	// target drives
	logic t_sda_o;
	logic t_sda_oe;
	logic int_o;
	logic int_oe;
	// resolved wire levels, pulled up when nobody pulls low
	logic scl;
	logic sda;
	logic int_line;
	assign scl = (scl_oe & ~scl_o) ? 1'b0 : 1'b1;
	assign sda = ((m_sda_oe & ~m_sda_o) | (t_sda_oe & ~t_sda_o)) ? 1'b0 : 1'b1;
	assign int_line = (int_oe & ~int_o) ? 1'b0 : 1'b1;
	modport tgt (input scl, input sda, output t_sda_o, output t_sda_oe, output int_o,
		output int_oe);
	modport ctrl (input sda, input int_line, output scl_o, output scl_oe, output m_sda_o,
		output m_sda_oe);
endinterface

// ==== core/lsip_sync.sv ====
// two-flop synchroniser for pin inputs, idles high like the bus
`timescale 1ns/1ns
module lsip_sync #(
	parameter int W = 1
)(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_r <= '1;
			q <= '1;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// ==== core/lsip_target.sv ====
// target end: two-wire register port of the light sensor
`timescale 1ns/1ns
// What this block and the controller end do
// RQ1: first byte after write address sets pointer
// RQ2: write is address, pointer, two acked bytes
// RQ3: read returns register of last stored pointer
// RQ4: controller reselects via pointer write then stop
// RQ5: read sends upper byte, then lower byte
// RQ6: controller ends read by nack, start, stop
// RQ7: pointer survives any number of reads
// RQ8: high-speed code not acked, filters switch
// RQ9: controller sends high-speed code at fast speed
// RQ10: stop returns filtering to standard/fast
// RQ11: controller keeps high speed with repeated starts
// RQ12: general call reset restores all registers
// RQ13: address byte follows address-select pin
// RQ14: alert response answered only when latch set
// RQ15: controller broadcasts alert response address as read
// RQ16: alerting target arbitrates address, winner clears alert
// RQ17: arbitration loser stays silent, alert stays
// RQ18: over-limit flag is address byte lsb
// RQ19: alert response keeps limit flags unchanged
// RQ20: five 16-bit registers at fixed pointers
// RQ21: sample register read-only, zero after reset
// RQ22: control read clears conversion done flag
// RQ23: pointer resets to sample register
// RQ24: read-only writes acked, values kept
module lsip_target
	import lsip_pkg::*;
#(
	parameter logic [15:0] LOWER_RST = 16'h0000,
	parameter logic [15:0] UPPER_RST = 16'hFFFF,
	parameter logic [15:0] MAKER_ID = 16'h5A5A // arbitrary value
)(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// two-wire link
	lsip_if.tgt bus,
	// address select strap pin
	input wire logic addr_sel,
	// conversion side
	input wire logic sample_load,
	input wire logic [15:0] sample_data,
	input wire logic over_limit_flag,
	input wire logic under_limit_flag,
	input wire logic alert_raise,
	// settings toward the converter
	output logic [15:0] control_o,
	output logic [15:0] lower_o,
	output logic [15:0] upper_o,
	output logic hs_filter_o,
	output logic gc_reset_o
);
	logic [2:0] pin_q;
	logic scl_q;
	logic sda_q;
	logic sel_q;
	logic scl_d_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	lsip_tgt_st_t state_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic [7:0] wr_hi_r;
	logic [15:0] tx_r;
	logic [15:0] ctl_r;
	logic [15:0] lower_r;
	logic [15:0] upper_r;
	logic [15:0] sample_r;
	logic [15:0] rd_word;
	logic [15:0] ctl_rd;
	logic [15:0] wr_word;
	logic second_r;
	logic ack_r;
	logic sda_oe_r;
	logic done_r;
	logic alert_r;
	logic hs_r;
	logic gc_r;
	logic [6:0] my_addr;
	logic byte_end;
	logic ack_end;
	logic addr_me;
	logic is_ara;
	logic is_hs;
	logic tx_mode;
	logic ptr_stb;
	logic wr_stb;
	logic gc_stb;
	logic rd_load;
	logic ara_win;

	lsip_sync #(.W(3)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.d({bus.scl, bus.sda, addr_sel}),
		.q(pin_q)
	);
	assign scl_q = pin_q[2];
	assign sda_q = pin_q[1];
	assign sel_q = pin_q[0];

	// last synchronised levels, for edges and bus conditions
	always_ff @(posedge mclk) begin
		if (reset) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_q;
			sda_d_r <= sda_q;
		end
	end

	// edges and start/stop, all on synchronised copies
	assign scl_rise = scl_q & ~scl_d_r;
	assign scl_fall = ~scl_q & scl_d_r;
	assign start_ev = scl_q & scl_d_r & sda_d_r & ~sda_q;
	assign stop_ev = scl_q & scl_d_r & ~sda_d_r & sda_q;
	assign my_addr = {TGT_ADDR_BASE[6:1], sel_q}; // see RQ13
	assign byte_end = scl_fall & (cnt_r == 4'h7);
	assign ack_end = scl_fall & (cnt_r == 4'h8);
	assign addr_me = shift_r[7:1] == my_addr;
	assign is_ara = (shift_r == ARA_BYTE) & ctl_r[CTL_LATCH] & alert_r; // see RQ14
	assign is_hs = shift_r[7:3] == HS_CODE;
	assign tx_mode = (state_r == T_RD) | (state_r == T_ARA);
	assign ptr_stb = byte_end & (state_r == T_PTR); // see RQ1
	assign wr_stb = byte_end & (state_r == T_WR) & second_r;
	assign gc_stb = byte_end & (state_r == T_GC) & (shift_r == GC_RESET);
	assign rd_load = ack_end & (state_r == T_RD) & ~second_r;
	assign ara_win = byte_end & (state_r == T_ARA);
	assign wr_word = {wr_hi_r, shift_r};

	// read mux; unmapped pointers read as zero
	always_comb begin
		ctl_rd = {ctl_r[15:9], 1'b0, done_r, over_limit_flag, under_limit_flag, ctl_r[4:0]};
		case (ptr_r) // see RQ3 RQ20
			PTR_OUTPUT_SAMPLE: rd_word = sample_r;
			PTR_OPERATING_CONTROL: rd_word = ctl_rd;
			PTR_LOWER_THRESHOLD: rd_word = lower_r;
			PTR_UPPER_THRESHOLD: rd_word = upper_r;
			PTR_MAKER_IDENTIFIER: rd_word = MAKER_ID;
			default: rd_word = 16'h0000;
		endcase
	end

	// bit and byte sequencing; start and stop override everything
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r <= T_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			wr_hi_r <= 8'h00;
			tx_r <= 16'h0000;
			second_r <= 1'b0;
			ack_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (start_ev) begin
			state_r <= T_ADDR;
			// the start's own scl fall is not a bit, so park the count until then
			cnt_r <= 4'hF;
			sda_oe_r <= 1'b0;
		end else if (stop_ev) begin
			state_r <= T_IDLE;
			cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
		end else begin
			if (scl_rise && cnt_r != 4'h8) begin
				shift_r <= {shift_r[6:0], sda_q};
				// released a one but line is low: lost
				if (state_r == T_ARA && !sda_oe_r && !sda_q) begin
					state_r <= T_IDLE; // see RQ17
				end
			end
			// controller nack ends a read
			if (scl_rise && cnt_r == 4'h8 && !ack_r && sda_q) begin
				state_r <= T_IDLE; // see RQ6
			end
			if (scl_fall && cnt_r == 4'hF) begin
				cnt_r <= 4'h0;
			end else if (scl_fall && cnt_r < 4'h7) begin
				cnt_r <= cnt_r + 4'h1;
				if (tx_mode) begin
					tx_r <= {tx_r[14:0], 1'b0};
					sda_oe_r <= ~tx_r[14];
				end
			end else if (byte_end) begin
				cnt_r <= 4'h8;
				tx_r <= {tx_r[14:0], 1'b0};
				case (state_r)
					T_ADDR: begin
						if (addr_me) begin
							state_r <= shift_r[0] ? T_RD : T_PTR;
							ack_r <= 1'b1; // see RQ2
							sda_oe_r <= 1'b1;
							second_r <= 1'b0;
						end else if (shift_r == GC_ADDR) begin
							state_r <= T_GC;
							ack_r <= 1'b1;
							sda_oe_r <= 1'b1;
						end else if (is_ara) begin
							state_r <= T_ARA;
							ack_r <= 1'b1;
							sda_oe_r <= 1'b1;
							// flags are only sampled here, never cleared
							tx_r <= {my_addr, over_limit_flag, 8'h00}; // see RQ16 RQ18 RQ19
						end else begin
							// not ours, or high-speed code: no ack
							state_r <= T_IDLE; // see RQ8
							ack_r <= 1'b0;
							sda_oe_r <= 1'b0;
						end
					end
					T_PTR: begin
						state_r <= T_WR;
						ack_r <= 1'b1;
						sda_oe_r <= 1'b1;
						second_r <= 1'b0;
					end
					T_WR: begin
						ack_r <= 1'b1; // see RQ2 RQ24
						sda_oe_r <= 1'b1;
						second_r <= ~second_r;
						wr_hi_r <= shift_r;
					end
					T_GC: begin
						state_r <= T_IDLE;
						ack_r <= shift_r == GC_RESET; // see RQ12
						sda_oe_r <= shift_r == GC_RESET;
					end
					T_RD: begin
						ack_r <= 1'b0;
						sda_oe_r <= 1'b0;
						second_r <= ~second_r;
					end
					default: begin
						ack_r <= 1'b0;
						sda_oe_r <= 1'b0;
					end
				endcase
			end else if (ack_end) begin
				cnt_r <= 4'h0;
				if (rd_load) begin
					// upper byte first, pointer untouched
					tx_r <= rd_word; // see RQ5 RQ7
					sda_oe_r <= ~rd_word[15];
				end else if (state_r == T_RD || (state_r == T_ARA && ack_r)) begin
					sda_oe_r <= ~tx_r[15];
				end else begin
					sda_oe_r <= 1'b0;
					if (state_r == T_ARA) begin
						state_r <= T_IDLE;
					end
				end
			end
		end
	end

	// pointer and writable registers
	always_ff @(posedge mclk) begin
		if (reset || gc_stb) begin
			ptr_r <= PTR_RST; // see RQ23
			ctl_r <= CONTROL_RST; // see RQ12
			lower_r <= LOWER_RST;
			upper_r <= UPPER_RST;
		end else begin
			if (ptr_stb) begin
				ptr_r <= shift_r; // see RQ1
			end
			if (wr_stb) begin
				case (ptr_r)
					PTR_OPERATING_CONTROL: begin
						// read-only bits keep their value
						ctl_r <= (wr_word & CONTROL_WMASK) | (ctl_r & ~CONTROL_WMASK); // see RQ24
					end
					PTR_LOWER_THRESHOLD: lower_r <= wr_word;
					PTR_UPPER_THRESHOLD: upper_r <= wr_word;
					default: ctl_r <= ctl_r;
				endcase
			end
		end
	end

	// sample and its done flag; a new sample beats a clearing read
	always_ff @(posedge mclk) begin
		if (reset || gc_stb) begin
			sample_r <= SAMPLE_RST; // see RQ21
			done_r <= 1'b0;
		end else if (sample_load) begin
			sample_r <= sample_data;
			done_r <= 1'b1;
		end else if (rd_load && ptr_r == PTR_OPERATING_CONTROL) begin
			done_r <= 1'b0; // see RQ22
		end else if (wr_stb && ptr_r == PTR_OPERATING_CONTROL &&
			wr_word[CTL_MODE_HI:CTL_MODE_LO] != 2'h0) begin
			done_r <= 1'b0;
		end
	end

	// alert latch; a new alert beats an arbitration win
	always_ff @(posedge mclk) begin
		if (reset || gc_stb) begin
			alert_r <= 1'b0;
		end else if (alert_raise) begin
			alert_r <= 1'b1;
		end else if (ara_win) begin
			alert_r <= 1'b0; // see RQ16
		end
	end

	// high-speed filter select and reset pulse
	always_ff @(posedge mclk) begin
		if (reset || stop_ev) begin
			hs_r <= 1'b0; // see RQ10
		end else if (byte_end && state_r == T_ADDR && is_hs) begin
			hs_r <= 1'b1; // see RQ8
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			gc_r <= 1'b0;
		end else begin
			gc_r <= gc_stb;
		end
	end

	// pins: alert pin low when alert differs from polarity
	assign bus.t_sda_o = 1'b0;
	assign bus.t_sda_oe = sda_oe_r;
	assign bus.int_o = 1'b0;
	assign bus.int_oe = alert_r ^ ctl_r[CTL_OUTPUT_POLARITY];
	assign control_o = ctl_r;
	assign lower_o = lower_r;
	assign upper_o = upper_r;
	assign hs_filter_o = hs_r;
	assign gc_reset_o = gc_r;
endmodule

// ==== core/lsip_ctrl.sv ====
// controller end: byte-level two-wire sequencer with clock divider
`timescale 1ns/1ns
module lsip_ctrl
	import lsip_pkg::*;
#(
	parameter int FS_KHZ = 100,
	parameter int HS_KHZ = 500
)(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// two-wire link
	lsip_if.ctrl bus,
	// byte command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack,
	// byte answers
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_ack,
	// link status
	output logic hs_active,
	output logic int_level
);
	// quarter bit times, rounded up so the rate never exceeds the setting
	localparam int FS_DIV = FS_KHZ * CLK_NS * 4;
	localparam int HS_DIV = HS_KHZ * CLK_NS * 4;
	localparam int FS_Q = (1000000 + FS_DIV - 1) / FS_DIV;
	localparam int HS_Q = (1000000 + HS_DIV - 1) / HS_DIV;
	localparam logic [7:0] FS_RLD = 8'(FS_Q - 1);
	localparam logic [7:0] HS_RLD = 8'(HS_Q - 1);

	logic [1:0] pin_q;
	logic sda_q;
	lsip_ctl_st_t state_r;
	logic [7:0] div_r;
	logic [1:0] q_r;
	logic [3:0] bit_r;
	logic [1:0] op_r;
	logic [7:0] sh_r;
	logic ackm_r;
	logic scl_oe_r;
	logic sda_oe_r;
	logic hs_r;
	logic first_r;
	logic rsp_r;
	logic ack_r;
	logic tick;

	lsip_sync #(.W(2)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.d({bus.sda, bus.int_line}),
		.q(pin_q)
	);
	assign sda_q = pin_q[1];

	// divider: code byte always goes at the slow rate
	assign tick = (div_r == 8'h00) & (state_r != H_IDLE);
	always_ff @(posedge mclk) begin
		if (reset || state_r == H_IDLE || tick) begin
			div_r <= hs_r ? HS_RLD : FS_RLD; // see RQ9
		end else begin
			div_r <= div_r - 8'h01;
		end
	end

	// four quarters per start, stop or bit
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r <= H_IDLE;
			q_r <= 2'h0;
			bit_r <= 4'h0;
			op_r <= OP_START;
			sh_r <= 8'h00;
			ackm_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			hs_r <= 1'b0;
			first_r <= 1'b0;
			rsp_r <= 1'b0;
			ack_r <= 1'b0;
		end else begin
			rsp_r <= 1'b0;
			if (cmd_valid && state_r == H_IDLE) begin
				op_r <= cmd_op;
				sh_r <= cmd_data;
				ackm_r <= cmd_ack;
				bit_r <= 4'h0;
				q_r <= 2'h0;
				case (cmd_op)
					OP_START: state_r <= H_START;
					OP_STOP: state_r <= H_STOP;
					default: state_r <= H_BIT;
				endcase
			end else if (tick) begin
				q_r <= q_r + 2'h1;
				case (state_r)
					H_START: begin
						// also a repeated start, keeping high speed
						case (q_r) // see RQ4 RQ11
							2'h0: sda_oe_r <= 1'b0;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b1;
							default: begin
								scl_oe_r <= 1'b1;
								first_r <= 1'b1;
								state_r <= H_IDLE;
							end
						endcase
					end
					H_STOP: begin
						case (q_r)
							2'h0: sda_oe_r <= 1'b1;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b0;
							default: begin
								hs_r <= 1'b0;
								state_r <= H_IDLE;
							end
						endcase
					end
					H_BIT: begin
						case (q_r)
							2'h0: begin
								if (bit_r == 4'h8) begin
									// read: ack asks for more, nack ends it
									sda_oe_r <= (op_r == OP_READ) & ackm_r; // see RQ5 RQ6
								end else begin
									sda_oe_r <= (op_r == OP_WRITE) & ~sh_r[7]; // see RQ2
								end
							end
							2'h1: scl_oe_r <= 1'b0;
							2'h2: begin
								if (bit_r == 4'h8) begin
									ack_r <= ~sda_q;
								end else begin
									sh_r <= {sh_r[6:0], sda_q};
								end
							end
							default: begin
								scl_oe_r <= 1'b1;
								bit_r <= bit_r + 4'h1;
								if (bit_r == 4'h8) begin
									rsp_r <= 1'b1;
									first_r <= 1'b0;
									state_r <= H_IDLE;
									if (op_r == OP_WRITE && first_r && sh_r[7:3] == HS_CODE) begin
										hs_r <= 1'b1;
									end
								end
							end
						endcase
					end
					default: state_r <= H_IDLE;
				endcase
			end
		end
	end

	// outputs; pins only ever pull low
	assign cmd_ready = state_r == H_IDLE;
	assign rsp_valid = rsp_r;
	assign rsp_data = sh_r;
	assign rsp_ack = ack_r;
	assign hs_active = hs_r;
	assign int_level = pin_q[0];
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = scl_oe_r;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_sda_oe = sda_oe_r;
endmodule

// ==== bench/lsip_link_props.sv ====
// wire-level checks on the two-wire link between controller and target
`timescale 1ns/1ns
module lsip_link_props (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// controller side of the link
	input wire logic scl,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	// target side of the link
	input wire logic t_sda_o,
	input wire logic t_sda_oe,
	input wire logic int_o,
	input wire logic int_oe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	logic [7:0] lo_cnt_r;
	// cycles since scl went low; saturates so a parked link cannot wrap it
	always_ff @(posedge mclk) begin
		if (reset || scl)
			lo_cnt_r <= 8'h00;
		else if (lo_cnt_r != 8'hFF)
			lo_cnt_r <= lo_cnt_r + 8'h01;
	end
	reset_release_a: assert property (disable iff (1'b0) reset |=> !t_sda_oe && !int_oe
		&& !scl_oe && !m_sda_oe) else $error("link not released after reset");
	tgt_open_drain_a: assert property (t_sda_o == 1'b0 && int_o == 1'b0)
		else $error("target drives a pin high");
	ctl_open_drain_a: assert property (scl_o == 1'b0 && m_sda_o == 1'b0)
		else $error("controller drives a pin high");
	tgt_hold_a: assert property (scl && $past(scl) |-> $stable(t_sda_oe))
		else $error("target changed sda while scl high");
	tgt_launch_a: assert property ($rose(t_sda_oe) |-> !scl && lo_cnt_r inside {[1:10]})
		else $error("target drive started outside scl low phase");
	tgt_release_a: assert property ($fell(t_sda_oe) |-> !scl && lo_cnt_r inside {[1:10]})
		else $error("target release outside scl low phase");
	scl_high_min_a: assert property ($rose(scl) |-> scl [*4])
		else $error("scl high phase too short");
	scl_low_min_a: assert property ($fell(scl) |-> !scl [*4])
		else $error("scl low phase too short");
endmodule

// ==== bench/light_sensor_i2c_register_port_tb.sv ====
// self-checking bench: controller end driving the target end over the link
`timescale 1ns/1ns
module light_sensor_i2c_register_port_tb;
	import lsip_pkg::*;
	localparam logic [7:0] ADDR_W = {TGT_ADDR_BASE[6:1], 1'b0, 1'b0};
	localparam logic [7:0] ADDR_R = {TGT_ADDR_BASE[6:1], 1'b0, 1'b1};
	logic mclk, reset, cmd_valid, cmd_ready, cmd_ack, rsp_valid, rsp_ack, hs_active, int_level;
	logic [1:0] cmd_op;
	logic [7:0] cmd_data, rsp_data;
	logic addr_sel, sample_load, over_limit_flag, under_limit_flag, alert_raise;
	logic [15:0] sample_data, control_o, lower_o, upper_o;
	logic hs_filter_o, gc_reset_o;
	int errors = 0;
	int n_compared = 0;
	lsip_if lsip_link();
	lsip_ctrl u_lsip_ctrl (.mclk(mclk), .reset(reset), .bus(lsip_link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .hs_active(hs_active),
		.int_level(int_level));
	lsip_target u_lsip_target (.mclk(mclk), .reset(reset), .bus(lsip_link), .addr_sel(addr_sel),
		.sample_load(sample_load), .sample_data(sample_data), .over_limit_flag(over_limit_flag),
		.under_limit_flag(under_limit_flag), .alert_raise(alert_raise), .control_o(control_o),
		.lower_o(lower_o), .upper_o(upper_o), .hs_filter_o(hs_filter_o), .gc_reset_o(gc_reset_o));
	lsip_link_props u_lsip_link_props (.mclk(mclk), .reset(reset), .scl(lsip_link.scl),
		.scl_o(lsip_link.scl_o), .scl_oe(lsip_link.scl_oe), .m_sda_o(lsip_link.m_sda_o),
		.m_sda_oe(lsip_link.m_sda_oe), .t_sda_o(lsip_link.t_sda_o),
		.t_sda_oe(lsip_link.t_sda_oe), .int_o(lsip_link.int_o), .int_oe(lsip_link.int_oe));
	// 10 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// verdict and end of run, shared by the tests and the watchdog
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one byte command; entered at a falling edge, held until taken while ready
	task automatic op(input logic [1:0] o, input logic [7:0] d, input logic a);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 4000) begin
			@(negedge mclk);
			n++;
		end
		cmd_op = o;
		cmd_data = d;
		cmd_ack = a;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		n = 0;
		// the answer pulse lasts one cycle, so it is caught on a falling edge
		while ((o == OP_WRITE || o == OP_READ) && rsp_valid !== 1'b1 && n < 4000) begin
			@(negedge mclk);
			n++;
		end
		// start and stop give no pulse: wait until the link has carried them out
		while (cmd_ready !== 1'b1 && n < 4000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 4000) begin
			errors++;
			$display("mismatch command wait expected ready seen busy");
		end
	endtask
	task automatic wb(input logic [7:0] d, input logic exp_ack);
		op(OP_WRITE, d, 1'b0);
		chk("byte ack", {15'h0000, exp_ack}, {15'h0000, rsp_ack});
	endtask
	task automatic set_ptr(input logic [7:0] p);
		op(OP_START, 8'h00, 1'b0);
		wb(ADDR_W, 1'b1);
		wb(p, 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
	endtask
	task automatic reg_wr(input logic [7:0] p, input logic [15:0] v);
		op(OP_START, 8'h00, 1'b0);
		wb(ADDR_W, 1'b1);
		wb(p, 1'b1);
		wb(v[15:8], 1'b1);
		wb(v[7:0], 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
	endtask
	// upper byte acked, lower byte nacked to end the read
	task automatic rd_word(input logic [15:0] exp, input string nm);
		logic [7:0] hi;
		op(OP_START, 8'h00, 1'b0);
		wb(ADDR_R, 1'b1);
		op(OP_READ, 8'h00, 1'b1);
		hi = rsp_data;
		op(OP_READ, 8'h00, 1'b0);
		chk(nm, exp, {hi, rsp_data});
		op(OP_STOP, 8'h00, 1'b0);
	endtask
	// watchdog sized above the expected run of about 68000 cycles
	initial begin
		repeat (90000) @(posedge mclk);
		errors++;
		$display("mismatch watchdog expected done seen hang");
		report_and_stop();
	end
	// main sequence
	initial begin
		{reset, cmd_valid, cmd_ack, addr_sel, sample_load, alert_raise} = 6'h20;
		{over_limit_flag, under_limit_flag} = 2'h0;
		cmd_op = OP_START;
		cmd_data = 8'h00;
		sample_data = 16'h0000;
		addr_sel = 1'b0;
		repeat (10) @(negedge mclk);
		reset = 1'b0;
		repeat (3) @(negedge mclk);
		rd_word(SAMPLE_RST, "reset sample");
		$display("test reset values done");
		reg_wr(PTR_UPPER_THRESHOLD, 16'h1234);
		chk("upper out", 16'h1234, upper_o);
		rd_word(16'h1234, "upper read");
		rd_word(16'h1234, "upper reread");
		reg_wr(PTR_OUTPUT_SAMPLE, 16'hBEEF);
		rd_word(SAMPLE_RST, "sample kept");
		set_ptr(PTR_MAKER_IDENTIFIER);
		rd_word(16'h5A5A, "maker id");
		$display("test write and read done");
		sample_data = 16'h3456;
		sample_load = 1'b1;
		@(negedge mclk);
		sample_load = 1'b0;
		set_ptr(PTR_OPERATING_CONTROL);
		rd_word(CONTROL_RST | 16'h0080, "done flag set");
		rd_word(CONTROL_RST, "done flag clear");
		set_ptr(PTR_OUTPUT_SAMPLE);
		rd_word(16'h3456, "sample");
		op(OP_START, 8'h00, 1'b0);
		wb(ADDR_W | 8'h02, 1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		addr_sel = 1'b1;
		op(OP_START, 8'h00, 1'b0);
		wb(ADDR_W | 8'h02, 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
		addr_sel = 1'b0;
		$display("test conversion and address done");
		op(OP_START, 8'h00, 1'b0);
		wb(8'h08, 1'b0);
		chk("hs filter on", 16'h0001, {15'h0000, hs_filter_o});
		chk("hs active", 16'h0001, {15'h0000, hs_active});
		op(OP_START, 8'h00, 1'b0);
		wb(ADDR_W, 1'b1);
		wb(PTR_LOWER_THRESHOLD, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h55, 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
		chk("hs filter off", 16'h0000, {15'h0000, hs_filter_o});
		rd_word(16'h0055, "lower");
		chk("lower out", 16'h0055, lower_o);
		$display("test high speed done");
		over_limit_flag = 1'b1;
		alert_raise = 1'b1;
		@(negedge mclk);
		alert_raise = 1'b0;
		op(OP_START, 8'h00, 1'b0);
		chk("int active", 16'h0000, {15'h0000, int_level});
		wb(ARA_BYTE, 1'b1);
		op(OP_READ, 8'h00, 1'b0);
		chk("alert addr", {8'h00, ADDR_W | 8'h01}, {8'h00, rsp_data});
		op(OP_STOP, 8'h00, 1'b0);
		chk("int cleared", 16'h0001, {15'h0000, int_level});
		reg_wr(PTR_OPERATING_CONTROL, 16'hC800);
		alert_raise = 1'b1;
		@(negedge mclk);
		alert_raise = 1'b0;
		op(OP_START, 8'h00, 1'b0);
		wb(ARA_BYTE, 1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		rd_word(16'hC840, "flags kept");
		$display("test alert response done");
		over_limit_flag = 1'b0;
		op(OP_START, 8'h00, 1'b0);
		wb(GC_ADDR, 1'b1);
		wb(GC_RESET, 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
		rd_word(SAMPLE_RST, "gc sample");
		set_ptr(PTR_UPPER_THRESHOLD);
		rd_word(16'hFFFF, "gc upper");
		set_ptr(PTR_OPERATING_CONTROL);
		rd_word(CONTROL_RST, "gc control");
		chk("gc control out", CONTROL_RST, control_o);
		$display("test general call done");
		report_and_stop();
	end
endmodule
